// *** verilog/iop_pkg.sv ***
// Summary of operation
// - scan port enabled only if test clock low
// - scan enabled: pull-ups on clock, mode, data-in
// - test clock pull-up on throughout reset
// - scan data-out driven, never pulled up
// - scan disabled: lines go to GPIO/mux
// - two-wire function selected on its pins after reset
// - two-wire: open-drain, spike-filtered; else ordinary line
// - each line has its own pull-up enable
// - reset: inputs except line 20, pull-ups off except test clock
// - reset: line 20 port A selects clock output F
// - USB pins follow USB function when selected
// - clock output off on reassign or keep-bit zero
// - clock output never re-enabled until power-up
package iop_pkg;
    // ----------------------------------------------------------------
    // line map
    // ----------------------------------------------------------------
    localparam int          PORT_A_LINES = 23;
    localparam int          PORT_B_LINES = 28;
    localparam int          NUM_LINES    = PORT_A_LINES + PORT_B_LINES;
    localparam int          IDX_W        = 6;
    localparam logic [5:0]  LINE_TCK     = 6'h00;
    localparam logic [5:0]  LINE_TMS     = 6'h01;
    localparam logic [5:0]  LINE_TDI     = 6'h02;
    localparam logic [5:0]  LINE_TDO     = 6'h03;
    localparam logic [5:0]  LINE_RC      = 6'h14;
    localparam logic [50:0] TWI_MASK     = 51'h0000_1822_00A0;
    localparam logic [50:0] USB_MASK     = 51'h0030_0000_0000;
    localparam logic [50:0] RC_MASK      = 51'h0000_0010_0000;
    // ----------------------------------------------------------------
    // function codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  FUNC_TWI     = 3'h0;
    localparam logic [2:0]  FUNC_USB     = 3'h1;
    localparam logic [2:0]  FUNC_F       = 3'h5;
    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [50:0] RST_GPIO     = ~(TWI_MASK | RC_MASK);
    localparam logic [50:0] RST_PUEN     = 51'h0000_0000_0001;
    localparam logic [50:0] RST_DIR      = 51'h0000_0000_0000;
    localparam logic [2:0]  RST_FUNC     = 3'h0;
    localparam logic [1:0]  SETTLE_CYC   = 2'h3;

    typedef enum logic [1:0] {
        SCN_WAIT = 2'b00,
        SCN_DONE = 2'b01
    } iop_scan_state_t;
endpackage

// *** verilog/iop_scan_if.sv ***
interface iop_scan_if;
    logic scan_en;
    logic scan_done;
    modport ctl (output scan_en, output scan_done);
    modport mon (input scan_en, input scan_done);
endinterface

// *** verilog/iop_scan_latch.sv ***
module iop_scan_latch
    import iop_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_tck_pin,
    iop_scan_if.ctl   scan
);
    logic            s1_r, s2_r, s3_r;
    logic [1:0]      cnt_r, cnt_nxt;
    logic            en_r, en_nxt;
    iop_scan_state_t st_r, st_nxt;

    // ----------------------------------------------------------------
    // decision
    // ----------------------------------------------------------------
    // the pin cannot be caught by the reset itself, so it is taken once the
    // synchroniser has refilled after release; the pull-up keeps it high meanwhile
    always_comb begin
        cnt_nxt = cnt_r;
        en_nxt  = en_r;
        st_nxt  = st_r;
        case (st_r)
            SCN_WAIT: begin
                if (cnt_r != SETTLE_CYC) begin
                    cnt_nxt = cnt_r + 2'h1;
                end else if (s2_r == s3_r) begin
                    en_nxt = ~s3_r;
                    st_nxt = SCN_DONE;
                end
            end
            SCN_DONE: begin
                st_nxt = SCN_DONE;
            end
            default: begin
                st_nxt = SCN_WAIT;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_r  <= 1'b1;
            s2_r  <= 1'b1;
            s3_r  <= 1'b1;
            cnt_r <= 2'h0;
            en_r  <= 1'b0;
            st_r  <= SCN_WAIT;
        end else begin
            s1_r  <= i_tck_pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            cnt_r <= cnt_nxt;
            en_r  <= en_nxt;
            st_r  <= st_nxt;
        end
    end

    assign scan.scan_en   = en_r;
    assign scan.scan_done = (st_r == SCN_DONE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    chk_scan_decide: assert property (
        (st_r == SCN_WAIT && cnt_r == SETTLE_CYC && s2_r == s3_r) |=> (en_r == !$past(s3_r)) && scan.scan_done)
        else $error("scan enable does not follow sampled test clock");
    chk_scan_hold: assert property (
        scan.scan_done |=> scan.scan_done && $stable(en_r))
        else $error("scan decision changed after it was latched");
    chk_scan_off_wait: assert property (
        !scan.scan_done |-> !en_r)
        else $error("scan port enabled before decision");
    cov_scan_on: cover property ($rose(en_r));
endmodule

// *** verilog/iop_pin_cfg.sv ***
module io_pin_reset_defaults
    import iop_pkg::*;
(
    input  wire logic             I_SYS_CLK,
    input  wire logic             I_RST_B,
    input  wire logic [50:0]      I_PAD_IN,
    input  wire logic [50:0]      I_PER_OUT,
    input  wire logic [50:0]      I_PER_OE,
    input  wire logic             I_SCAN_TDO,
    input  wire logic             I_RC32_LEVEL,
    input  wire logic             I_CFG_WE,
    input  wire logic [IDX_W-1:0] I_CFG_LINE,
    input  wire logic             I_CFG_GPIO,
    input  wire logic [2:0]       I_CFG_FUNC,
    input  wire logic             I_CFG_PUEN,
    input  wire logic             I_CFG_DIR,
    input  wire logic             I_CFG_OUT,
    input  wire logic             I_KEEP_WE,
    input  wire logic             I_KEEP_VAL,
    output logic      [50:0]      O_PAD_OUT,
    output logic      [50:0]      O_PAD_OE_B,
    output logic      [50:0]      O_PAD_PU,
    output logic      [50:0]      O_LINE_IN,
    output logic                  O_SCAN_EN,
    output logic                  O_RC_OUT_ON
);
    iop_scan_if scan_bus ();

    iop_scan_latch u_scan (
        .i_clk     (I_SYS_CLK),
        .i_rst_b   (I_RST_B),
        .i_tck_pin (I_PAD_IN[0]),
        .scan      (scan_bus.ctl)
    );

    // ----------------------------------------------------------------
    // per-line configuration store
    // ----------------------------------------------------------------
    logic [50:0] gpio_r, gpio_nxt;
    logic [50:0] puen_r, puen_nxt;
    logic [50:0] dir_r, dir_nxt;
    logic [50:0] dout_r, dout_nxt;
    logic [2:0]  func_r   [NUM_LINES];
    logic [2:0]  func_nxt [NUM_LINES];

    always_comb begin
        gpio_nxt = gpio_r;
        puen_nxt = puen_r;
        dir_nxt  = dir_r;
        dout_nxt = dout_r;
        func_nxt = func_r;
        // out-of-range indices are dropped rather than aliased
        if (I_CFG_WE && (int'(I_CFG_LINE) < NUM_LINES)) begin
            gpio_nxt[I_CFG_LINE] = I_CFG_GPIO;
            puen_nxt[I_CFG_LINE] = I_CFG_PUEN;
            dir_nxt[I_CFG_LINE]  = I_CFG_DIR;
            dout_nxt[I_CFG_LINE] = I_CFG_OUT;
            func_nxt[I_CFG_LINE] = I_CFG_FUNC;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            gpio_r <= RST_GPIO;
            puen_r <= RST_PUEN;
            dir_r  <= RST_DIR;
            dout_r <= '0;
            for (int i = 0; i < NUM_LINES; i++) begin
                func_r[i] <= (i == int'(LINE_RC)) ? FUNC_F : RST_FUNC;
            end
        end else begin
            gpio_r <= gpio_nxt;
            puen_r <= puen_nxt;
            dir_r  <= dir_nxt;
            dout_r <= dout_nxt;
            func_r <= func_nxt;
        end
    end

    // ----------------------------------------------------------------
    // slow clock output enable
    // ----------------------------------------------------------------
    // one-way: once dropped it stays dropped; only a power-up reset restores it
    logic rc_on_r, rc_on_nxt;
    logic rc1_r, rc2_r, rc3_r;
    logic rc_lvl_r, rc_lvl_nxt;

    always_comb begin
        rc_on_nxt  = rc_on_r;
        rc_lvl_nxt = rc_lvl_r;
        // the oscillator level is taken only once two sync stages agree
        if (rc2_r == rc3_r) begin
            rc_lvl_nxt = rc3_r;
        end
        if (gpio_r[LINE_RC] || func_r[LINE_RC] != FUNC_F || (I_KEEP_WE && !I_KEEP_VAL)) begin
            rc_on_nxt = 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rc_on_r <= 1'b1;
            rc1_r   <= 1'b0;
            rc2_r   <= 1'b0;
            rc3_r   <= 1'b0;
            rc_lvl_r <= 1'b0;
        end else begin
            rc_on_r <= rc_on_nxt;
            rc1_r   <= I_RC32_LEVEL;
            rc2_r   <= rc1_r;
            rc3_r   <= rc2_r;
            rc_lvl_r <= rc_lvl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // input sampling
    // ----------------------------------------------------------------
    logic [50:0] in1_r, in2_r, in3_r, in4_r;
    logic [50:0] lin_r, lin_nxt;
    logic [50:0] twi_on;

    always_comb begin
        lin_nxt = lin_r;
        for (int i = 0; i < NUM_LINES; i++) begin
            twi_on[i] = TWI_MASK[i] && !gpio_r[i] && func_r[i] == FUNC_TWI;
            // two-wire lines need one more agreeing sample to reject spikes
            if (in2_r[i] == in3_r[i] && (!twi_on[i] || in3_r[i] == in4_r[i])) begin
                lin_nxt[i] = in3_r[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // pad drive
    // ----------------------------------------------------------------
    logic [50:0] pout_r, pout_nxt;
    logic [50:0] poe_b_r, poe_b_nxt;
    logic [50:0] ppu_r, ppu_nxt;
    logic        scan_en;

    assign scan_en = scan_bus.scan_en;

    always_comb begin
        pout_nxt  = '0;
        poe_b_nxt = '1;
        ppu_nxt   = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (scan_en && (i == int'(LINE_TCK) || i == int'(LINE_TMS) || i == int'(LINE_TDI))) begin
                ppu_nxt[i] = 1'b1;
            end else if (scan_en && i == int'(LINE_TDO)) begin
                pout_nxt[i]  = I_SCAN_TDO;
                poe_b_nxt[i] = 1'b0;
            end else if (gpio_r[i]) begin
                pout_nxt[i]  = dout_r[i];
                poe_b_nxt[i] = ~dir_r[i];
                ppu_nxt[i]   = puen_r[i];
            end else if (twi_on[i]) begin
                poe_b_nxt[i] = I_PER_OUT[i];
                ppu_nxt[i]   = puen_r[i];
            end else if (i == int'(LINE_RC) && func_r[i] == FUNC_F) begin
                pout_nxt[i]  = rc_lvl_r;
                poe_b_nxt[i] = ~rc_on_r;
                ppu_nxt[i]   = puen_r[i];
            end else begin
                // covers USB pins in USB function and every other peripheral
                pout_nxt[i]  = I_PER_OUT[i];
                poe_b_nxt[i] = ~I_PER_OE[i];
                ppu_nxt[i]   = puen_r[i];
            end
        end
        // test clock pull-up stays on until the scan decision is taken
        if (!scan_bus.scan_done) begin
            ppu_nxt[LINE_TCK] = 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            in1_r   <= '1;
            in2_r   <= '1;
            in3_r   <= '1;
            in4_r   <= '1;
            lin_r   <= '1;
            pout_r  <= '0;
            poe_b_r <= '1;
            ppu_r   <= RST_PUEN;
            O_SCAN_EN   <= 1'b0;
            O_RC_OUT_ON <= 1'b1;
        end else begin
            in1_r   <= I_PAD_IN;
            in2_r   <= in1_r;
            in3_r   <= in2_r;
            in4_r   <= in3_r;
            lin_r   <= lin_nxt;
            pout_r  <= pout_nxt;
            poe_b_r <= poe_b_nxt;
            ppu_r   <= ppu_nxt;
            O_SCAN_EN   <= scan_en;
            O_RC_OUT_ON <= rc_on_r;
        end
    end

    assign O_PAD_OUT  = pout_r;
    assign O_PAD_OE_B = poe_b_r;
    assign O_PAD_PU   = ppu_r;
    assign O_LINE_IN  = lin_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);

    chk_tdo_no_pull: assert property (
        scan_en |=> !O_PAD_PU[LINE_TDO] && !O_PAD_OE_B[LINE_TDO] && O_PAD_OUT[LINE_TDO] == $past(I_SCAN_TDO))
        else $error("scan data-out not driven or pulled up");
    chk_scan_pullups: assert property (
        scan_en |=> O_PAD_PU[LINE_TCK] && O_PAD_PU[LINE_TMS] && O_PAD_PU[LINE_TDI])
        else $error("scan input pull-up missing");
    chk_rc_never_back: assert property (
        !rc_on_r |=> !rc_on_r ##1 !O_RC_OUT_ON)
        else $error("clock output came back");
    chk_rc_keep_zero: assert property (
        I_KEEP_WE && !I_KEEP_VAL |=> !rc_on_r ##1 (!O_RC_OUT_ON && (O_PAD_OE_B[LINE_RC]
            || $past(gpio_r[LINE_RC]) || $past(func_r[LINE_RC]) != FUNC_F)))
        else $error("clock output survived keep-bit clear");
    chk_twi_open_drain: assert property (
        (twi_on[5] && !scan_en) |=> !O_PAD_OUT[5] && O_PAD_OE_B[5] == $past(I_PER_OUT[5]))
        else $error("two-wire line not open-drain");
    chk_gpio_pullup: assert property (
        (I_CFG_WE && I_CFG_GPIO && I_CFG_LINE == 6'h0A) |=> ##1 O_PAD_PU[10] == $past(I_CFG_PUEN, 2))
        else $error("line pull-up does not follow its enable");
    cov_twi_reassign: cover property (twi_on[5] ##1 !twi_on[5]);
    cov_rc_drop: cover property ($fell(rc_on_r));
endmodule

// *** sim/iop_board_model.sv ***
module iop_board_model
    import iop_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic [50:0] i_pad_out,
    input  wire logic [50:0] i_pad_oe_b,
    input  wire logic [50:0] i_pad_pu,
    input  wire logic [50:0] i_ext_en,
    input  wire logic [50:0] i_ext_val,
    output logic      [50:0] o_pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // wire resolution
    // ----------------------------------------------------------------
    // a line nobody drives and nobody pulls up wanders every cycle, so a
    // stale level can never pass for a real one
    logic [50:0] float_r = 51'h5_5555_5555_5555;
    always @(posedge i_clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 51; i++) begin
            if (i_pad_oe_b[i] == 1'h0) begin
                o_pad_in[i] = i_pad_out[i];
            end else if (i_ext_en[i] == 1'h1) begin
                o_pad_in[i] = i_ext_val[i];
            end else if (i_pad_pu[i] == 1'h1) begin
                o_pad_in[i] = 1'h1;
            end else begin
                o_pad_in[i] = float_r[i];
            end
        end
    end
endmodule

// *** sim/io_pin_reset_defaults_test.sv ***
module io_pin_reset_defaults_test
    import iop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_b, scan_tdo, rc_level, cfg_we, cfg_gpio, cfg_pu, cfg_dir, cfg_out;
    logic        keep_we, keep_val, scan_en, rc_on;
    logic [5:0]  cfg_line;
    logic [2:0]  cfg_func;
    logic [50:0] pad_in, per_out, per_oe, ext_en, ext_val, pad_out, pad_oe_b, pad_pu, line_in;
    int          miscompares = 0;
    int          checks = 0;
    io_pin_reset_defaults i_io_pin_reset_defaults (.I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_PAD_IN(pad_in),
        .I_PER_OUT(per_out), .I_PER_OE(per_oe), .I_SCAN_TDO(scan_tdo), .I_RC32_LEVEL(rc_level),
        .I_CFG_WE(cfg_we), .I_CFG_LINE(cfg_line), .I_CFG_GPIO(cfg_gpio), .I_CFG_FUNC(cfg_func),
        .I_CFG_PUEN(cfg_pu), .I_CFG_DIR(cfg_dir), .I_CFG_OUT(cfg_out), .I_KEEP_WE(keep_we),
        .I_KEEP_VAL(keep_val), .O_PAD_OUT(pad_out), .O_PAD_OE_B(pad_oe_b), .O_PAD_PU(pad_pu),
        .O_LINE_IN(line_in), .O_SCAN_EN(scan_en), .O_RC_OUT_ON(rc_on));
    iop_board_model i_iop_board_model (.i_clk(sys_clk), .i_pad_out(pad_out), .i_pad_oe_b(pad_oe_b),
        .i_pad_pu(pad_pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad_in(pad_in));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [50:0] seen, input logic [50:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic cfg(input logic [5:0] ln, input logic g, input logic [2:0] f, input logic p, d, o);
        @(posedge sys_clk);
        cfg_we   <= 1'h1;
        cfg_line <= ln;
        cfg_gpio <= g;
        cfg_func <= f;
        cfg_pu   <= p;
        cfg_dir  <= d;
        cfg_out  <= o;
        @(posedge sys_clk);
        cfg_we <= 1'h0;
        tick(4);
    endtask
    task automatic keep(input logic v);
        @(posedge sys_clk);
        keep_we  <= 1'h1;
        keep_val <= v;
        @(posedge sys_clk);
        keep_we <= 1'h0;
        tick(4);
    endtask
    // reset pin is only ever moved by the bench; no debug session shares it
    task automatic do_reset(input logic tck_low);
        ext_en[0]  <= tck_low;
        ext_val[0] <= 1'h0;
        rst_b      <= 1'h0;
        tick(6);
        check("tck pull-up in reset", pad_pu[0], 1'h1);
        rst_b <= 1'h1;
        tick(12);
        ext_en[0]  <= 1'h1;
        ext_val[0] <= tck_low;
        tick(10);
        ext_en[0] <= 1'h0;
        check("scan enable", scan_en, tck_low);
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_scan_on();
        do_reset(1'h1);
        check("scan pull-ups", pad_pu[3:0], 4'h7);
        check("tdo drive", pad_oe_b[3], 1'h0);
        scan_tdo <= ~scan_tdo;
        tick(3);
        check("tdo data", pad_out[3], scan_tdo);
        cfg(6'h01, 1'h1, 3'h0, 1'h0, 1'h1, 1'h1);
        check("tms kept from gpio", pad_oe_b[1], 1'h1);
        $display("test scan_on done");
    endtask
    task automatic t_scan_off();
        do_reset(1'h0);
        check("reset pull-ups", pad_pu, RST_PUEN);
        check("reset directions", pad_oe_b, ~RC_MASK);
        cfg(6'h00, 1'h1, 3'h0, 1'h1, 1'h1, 1'h0);
        check("line0 gpio out", pad_oe_b[0], 1'h0);
        cfg(6'h01, 1'h1, 3'h0, 1'h0, 1'h1, 1'h1);
        check("line1 gpio out", {pad_oe_b[1], pad_out[1]}, 2'h1);
        $display("test scan_off done");
    endtask
    task automatic t_two_wire();
        for (int l = 0; l < 51; l++) begin
            if (TWI_MASK[l]) begin
                per_out[l] <= 1'h0;
                tick(4);
                check("two-wire pulls low", {pad_oe_b[l], pad_out[l]}, 2'h0);
                per_out[l] <= 1'h1;
                tick(4);
                check("two-wire released", pad_oe_b[l], 1'h1);
            end
        end
        // two-cycle low pulse: a plain line takes it, a two-wire line filters it
        ext_en[8:7]  <= 2'h3;
        ext_val[8:7] <= 2'h3;
        tick(6);
        ext_val[8:7] <= 2'h0;
        tick(2);
        ext_val[8:7] <= 2'h3;
        tick(3);
        check("spike on plain line", line_in[8], 1'h0);
        check("spike on two-wire line", line_in[7], 1'h1);
        ext_en[8:7] <= 2'h0;
        per_out[5] <= 1'h0;
        cfg(6'h05, 1'h1, 3'h0, 1'h0, 1'h1, 1'h1);
        check("two-wire as gpio", {pad_oe_b[5], pad_out[5]}, 2'h1);
        $display("test two_wire done");
    endtask
    task automatic t_pullup();
        cfg(6'h0A, 1'h1, 3'h0, 1'h1, 1'h0, 1'h0);
        cfg(6'h0B, 1'h1, 3'h0, 1'h1, 1'h0, 1'h0);
        cfg(6'h33, 1'h1, 3'h0, 1'h1, 1'h0, 1'h0);
        check("pull-up pair", pad_pu[12:10], 3'h3);
        cfg(6'h0A, 1'h1, 3'h0, 1'h0, 1'h0, 1'h0);
        check("pull-up single", pad_pu[12:10], 3'h2);
        ext_en[12]  <= 1'h1;
        ext_val[12] <= 1'h0;
        tick(8);
        check("line inputs", {line_in[12], line_in[11]}, 2'h1);
        ext_en[12] <= 1'h0;
        $display("test pullup done");
    endtask
    task automatic t_usb();
        for (int l = 0; l < 51; l++) begin
            if (USB_MASK[l]) begin
                cfg(l[5:0], 1'h0, FUNC_USB, 1'h0, 1'h0, 1'h0);
                per_oe[l]  <= 1'h1;
                per_out[l] <= 1'h0;
                tick(4);
                check("usb drive", {pad_oe_b[l], pad_out[l]}, 2'h0);
                per_oe[l] <= 1'h0;
                cfg(l[5:0], 1'h1, 3'h0, 1'h0, 1'h1, 1'h1);
                check("usb line as gpio", {pad_oe_b[l], pad_out[l]}, 2'h1);
            end
        end
        $display("test usb done");
    endtask
    task automatic t_rc(input int kind);
        do_reset(1'h0);
        check("rc default", {rc_on, pad_oe_b[20]}, 2'h2);
        rc_level <= 1'h1;
        tick(8);
        check("rc high", pad_out[20], 1'h1);
        rc_level <= 1'h0;
        tick(8);
        check("rc low", pad_out[20], 1'h0);
        keep(1'h1);
        check("rc kept", rc_on, 1'h1);
        if (kind == 0) keep(1'h0);
        if (kind == 1) cfg(6'h14, 1'h1, 3'h0, 1'h0, 1'h0, 1'h0);
        if (kind == 2) cfg(6'h14, 1'h0, FUNC_TWI, 1'h0, 1'h0, 1'h0);
        check("rc off", {rc_on, pad_oe_b[20]}, 2'h1);
        keep(1'h1);
        cfg(6'h14, 1'h0, FUNC_F, 1'h0, 1'h0, 1'h0);
        check("rc stays off", rc_on, 1'h0);
        $display("test rc kind %0d done", kind);
    endtask
    // ----------------------------------------------------------------
    // stimulus and run control
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        miscompares++;
        $display("ERROR watchdog expected end seen hang");
        final_report();
    end
    initial begin
        rst_b    = 1'h0;
        scan_tdo = 1'h0;
        rc_level = 1'h0;
        cfg_we   = 1'h0;
        cfg_line = 6'h00;
        cfg_gpio = 1'h0;
        cfg_func = 3'h0;
        cfg_pu   = 1'h0;
        cfg_dir  = 1'h0;
        cfg_out  = 1'h0;
        keep_we  = 1'h0;
        keep_val = 1'h1;
        per_out  = {51{1'h1}};
        per_oe   = 51'h0;
        ext_en   = 51'h0;
        ext_val  = 51'h0;
        t_scan_on();
        t_scan_off();
        t_two_wire();
        t_pullup();
        t_usb();
        for (int k = 0; k < 3; k++) t_rc(k);
        final_report();
    end
endmodule
